/* File: design/clp_defines.svh */
`ifndef CLP_DEFINES_SVH
`define CLP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define CLP_OFF_CTRL      12'h000
`define CLP_OFF_GROUP_SEL 12'h004
`define CLP_OFF_STATUS    12'h008
`define CLP_OFF_COUNT     12'h00C
`define CLP_OFF_PREFAULT  12'h010
`define CLP_OFF_EV_LAST   12'h014
`define CLP_OFF_EV_TIME   12'h018
`define CLP_OFF_BLK_CUR   12'h01C
`define CLP_OFF_GROUP0    12'h100

// Group setting word order inside a group (stride 0x20).
`define CLP_GSTRIDE       12'h020
`define CLP_GW_LOW        3'd0
`define CLP_GW_HIGH       3'd1
`define CLP_GW_OVER       3'd2
`define CLP_GW_START_DELAY_TIME       3'd3
`define CLP_GW_MAXIMUM_INRUSH_TIME       3'd4
`define CLP_GW_MINIMUM_HOLD_TIME       3'd5

// Control bits.
`define CLP_CTRL_FORCE_EN  0
`define CLP_CTRL_FORCE_BLK 1
`define CLP_CTRL_CNT_CLR   2

// ----------------------------------------------------------------------------
// Reset values (currents in 0.01 per unit, times in 5 ms ticks)
// ----------------------------------------------------------------------------
`define CLP_RST_LOW   16'h0014
`define CLP_RST_HIGH  16'h0078
`define CLP_RST_OVER  16'h00C8
`define CLP_RST_START_DELAY_TIME  20'h0_07D0
`define CLP_RST_MAXIMUM_INRUSH_TIME  20'h0_1770
`define CLP_RST_MINIMUM_HOLD_TIME  20'h0_0008

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLP_CLK_HZ      200000000
`define CLP_TICK_MS     5
`define CLP_TICK_CYC    ((`CLP_CLK_HZ / 1000) * `CLP_TICK_MS)
`define CLP_MS_CYC      (`CLP_CLK_HZ / 1000)
`define CLP_HYST_PCT    97

`endif

/* File: design/clp_pkg.sv */
package clp_pkg;
    typedef enum logic [2:0] {
        CLP_COND_NORMAL  = 3'h0,
        CLP_COND_LOW     = 3'h1,
        CLP_COND_OVER    = 3'h2,
        CLP_COND_ACTIVE  = 3'h3,
        CLP_COND_BLOCKED = 3'h4
    } clp_cond_e;

    typedef enum logic [1:0] {
        CLP_ST_IDLE   = 2'b00,
        CLP_ST_ARMING = 2'b01,
        CLP_ST_ACTIVE = 2'b11,
        CLP_ST_BLOCK  = 2'b10
    } clp_state_e;
endpackage : clp_pkg

/* File: design/clp_cmp.sv */
`include "clp_defines.svh"

module clp_cmp #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         tick,
    input  wire logic         above,
    input  wire logic [W-1:0] level,
    input  wire logic [W-1:0] thr,
    output logic              met
);
    logic [W+6:0] lv100;
    logic [W+6:0] th97;
    logic [W+6:0] th100;

    assign lv100 = (W+7)'(level) * (W+7)'(100);
    assign th100 = (W+7)'(thr) * (W+7)'(100);
    assign th97  = (W+7)'(thr) * (W+7)'(`CLP_HYST_PCT);

    // Hysteresis: a met condition only clears once past 97 % (above) or 103 % (below) of the setting.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            met <= 1'b0;
        end else if (tick) begin
            if (above) begin
                met <= met ? (lv100 > th97) : (lv100 > th100);
            end else begin
                met <= met ? (lv100 < th100 + (th100 - th97)) : (lv100 < th100);
            end
        end
    end
endmodule : clp_cmp

/* File: design/clp_detector.sv */
`include "clp_defines.svh"

module clp_detector #(
    parameter int TICK_CYC = `CLP_TICK_CYC,
    parameter int MS_CYC   = `CLP_MS_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] phase_a_rms,
    input  wire logic [15:0] phase_b_rms,
    input  wire logic [15:0] phase_c_rms,
    input  wire logic        block_in,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             cold_load_active,
    output logic             blocked,
    output logic             event_valid,
    output logic [1:0]       event_code,
    output logic [31:0]      event_time
);
    // ------------------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------------------
    logic [31:0] tick_cnt_r;
    logic [31:0] ms_cnt_r;
    logic [31:0] ms_time_r;
    logic        tick;

    assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_r <= 32'h0000_0000;
        end else begin
            tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt_r  <= 32'h0000_0000;
            ms_time_r <= 32'h0000_0000;
        end else if (ms_cnt_r == 32'(MS_CYC - 1)) begin
            ms_cnt_r  <= 32'h0000_0000;
            ms_time_r <= ms_time_r + 32'h0000_0001;
        end else begin
            ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    logic [15:0] pa_s1, pb_s1, pc_s1, pa_s2, pb_s2, pc_s2;
    logic        blk_s1, blk_s2;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pa_s1  <= 16'h0000;
            pb_s1  <= 16'h0000;
            pc_s1  <= 16'h0000;
            pa_s2  <= 16'h0000;
            pb_s2  <= 16'h0000;
            pc_s2  <= 16'h0000;
            blk_s1 <= 1'b0;
            blk_s2 <= 1'b0;
        end else begin
            pa_s1  <= phase_a_rms;
            pb_s1  <= phase_b_rms;
            pc_s1  <= phase_c_rms;
            pa_s2  <= pa_s1;
            pb_s2  <= pb_s1;
            pc_s2  <= pc_s1;
            blk_s1 <= block_in;
            blk_s2 <= blk_s1;
        end
    end

    // ------------------------------------------------------------------------
    // Settings groups and control
    // ------------------------------------------------------------------------
    logic [15:0] thr_r [8][3];
    logic [19:0] tim_r [8][3];
    logic [2:0]  group_sel_r;
    logic        force_en_r;
    logic        force_blk_r;
    logic        wr;
    logic [2:0]  wgrp;
    logic [2:0]  wword;

    assign wr    = psel && penable && pwrite;
    assign wgrp  = paddr[7:5];
    assign wword = paddr[4:2];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int g = 0; g < 8; g++) begin
                thr_r[g][0] <= `CLP_RST_LOW;
                thr_r[g][1] <= `CLP_RST_HIGH;
                thr_r[g][2] <= `CLP_RST_OVER;
                tim_r[g][0] <= `CLP_RST_START_DELAY_TIME;
                tim_r[g][1] <= `CLP_RST_MAXIMUM_INRUSH_TIME;
                tim_r[g][2] <= `CLP_RST_MINIMUM_HOLD_TIME;
            end
        end else if (wr && paddr[11:8] == 4'h1) begin
            if (wword < `CLP_GW_START_DELAY_TIME) begin
                thr_r[wgrp][2'(wword)] <= pwdata[15:0];
            end else if (wword <= `CLP_GW_MINIMUM_HOLD_TIME) begin
                tim_r[wgrp][2'(wword - `CLP_GW_START_DELAY_TIME)] <= pwdata[19:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            group_sel_r <= 3'h0;
            force_en_r  <= 1'b0;
            force_blk_r <= 1'b0;
        end else if (wr && paddr == `CLP_OFF_GROUP_SEL) begin
            group_sel_r <= pwdata[2:0];
        end else if (wr && paddr == `CLP_OFF_CTRL) begin
            force_en_r  <= pwdata[`CLP_CTRL_FORCE_EN];
            force_blk_r <= pwdata[`CLP_CTRL_FORCE_BLK];
        end
    end

    // ------------------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------------------
    logic [2:0] low_m, high_m, over_m;
    logic [15:0] ph [3];

    assign ph[0] = pa_s2;
    assign ph[1] = pb_s2;
    assign ph[2] = pc_s2;

    for (genvar p = 0; p < 3; p++) begin : g_ph
        clp_cmp u_low (.clk(clk), .rst_n(rst_n), .tick(tick), .above(1'b0), .level(ph[p]),
                       .thr(thr_r[group_sel_r][0]), .met(low_m[p]));
        clp_cmp u_high (.clk(clk), .rst_n(rst_n), .tick(tick), .above(1'b1), .level(ph[p]),
                        .thr(thr_r[group_sel_r][1]), .met(high_m[p]));
        clp_cmp u_over (.clk(clk), .rst_n(rst_n), .tick(tick), .above(1'b1), .level(ph[p]),
                        .thr(thr_r[group_sel_r][2]), .met(over_m[p]));
    end

    logic low_c, high_c, over_c, eval;
    assign low_c  = &low_m;
    assign high_c = &high_m;
    assign over_c = |over_m;

    // Comparators settle on tick; the decision runs one cycle later.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eval <= 1'b0;
        end else begin
            eval <= tick;
        end
    end

    // ------------------------------------------------------------------------
    // Blocking sample and pick-up state machine
    // ------------------------------------------------------------------------
    logic               blk_r;
    logic               blk_now;
    clp_pkg::clp_state_e state_r;
    logic [19:0]        t_set_r, t_max_r, t_min_r;
    logic               inrush_r;

    // Sampled once per tick so the decision sees one stable value.
    assign blk_now = force_en_r ? force_blk_r : blk_s2;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blk_r <= 1'b0;
        end else if (tick) begin
            blk_r <= blk_now;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= clp_pkg::CLP_ST_IDLE;
            t_set_r  <= 20'h0_0000;
            t_max_r  <= 20'h0_0000;
            t_min_r  <= 20'h0_0000;
            inrush_r <= 1'b0;
        end else if (eval) begin
            unique case (state_r)
                clp_pkg::CLP_ST_IDLE: begin
                    t_set_r <= 20'h0_0000;
                    if (low_c) begin
                        state_r <= clp_pkg::CLP_ST_ARMING;
                    end
                end
                clp_pkg::CLP_ST_ARMING: begin
                    if (!low_c) begin
                        state_r <= clp_pkg::CLP_ST_IDLE;
                    end else if (t_set_r + 20'h0_0001 >= tim_r[group_sel_r][0]) begin
                        state_r  <= blk_r ? clp_pkg::CLP_ST_BLOCK
                                          : clp_pkg::CLP_ST_ACTIVE;
                        t_max_r  <= 20'h0_0000;
                        t_min_r  <= 20'h0_0000;
                        inrush_r <= 1'b0;
                    end else begin
                        t_set_r <= t_set_r + 20'h0_0001;
                    end
                end
                clp_pkg::CLP_ST_ACTIVE: begin
                    t_min_r <= t_min_r + 20'h0_0001;
                    if (high_c) begin
                        inrush_r <= 1'b1;
                        t_max_r  <= t_max_r + 20'h0_0001;
                    end
                    if (over_c || blk_r) begin
                        state_r <= clp_pkg::CLP_ST_IDLE;
                    end else if (high_c && t_max_r + 20'h0_0001 >= tim_r[group_sel_r][1]) begin
                        state_r <= clp_pkg::CLP_ST_IDLE;
                    end else if (!high_c && !low_c
                                 && t_min_r + 20'h0_0001 >= tim_r[group_sel_r][2]) begin
                        state_r <= clp_pkg::CLP_ST_IDLE;
                    end
                end
                clp_pkg::CLP_ST_BLOCK: begin
                    if (!blk_r || !low_c) begin
                        state_r <= clp_pkg::CLP_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Activation drops the same cycle an overcurrent is seen, not at the next tick.
    assign cold_load_active = (state_r == clp_pkg::CLP_ST_ACTIVE) && !(over_c && eval);
    assign blocked          = (state_r == clp_pkg::CLP_ST_BLOCK);

    // ------------------------------------------------------------------------
    // Events, counter, pre-fault history
    // ------------------------------------------------------------------------
    logic        act_d, blk_d, cnt_clr;
    logic [31:0] count_r;
    logic [15:0] hist_r [8];
    logic [17:0] avg;
    logic [15:0] prefault_r;
    logic [15:0] blk_cur_r;

    assign cnt_clr = wr && paddr == `CLP_OFF_CTRL && pwdata[`CLP_CTRL_CNT_CLR];
    // Entries 4..7 hold 20..40 ms ago: the 20 ms window ending 20 ms back.
    assign avg = (18'(hist_r[4]) + 18'(hist_r[5]) + 18'(hist_r[6]) + 18'(hist_r[7])) >> 2;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            act_d       <= 1'b0;
            blk_d       <= 1'b0;
            event_valid <= 1'b0;
            event_code  <= 2'b00;
            event_time  <= 32'h0000_0000;
        end else begin
            act_d       <= cold_load_active;
            blk_d       <= blocked;
            event_valid <= (act_d != cold_load_active) || (blk_d != blocked);
            // Code and stamp hold between events so software reads the last one.
            if ((act_d != cold_load_active) || (blk_d != blocked)) begin
                event_code <= (blk_d != blocked) ? {1'b1, blocked} : {1'b0, cold_load_active};
                event_time <= ms_time_r;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= 32'h0000_0000;
        end else if ((cold_load_active && !act_d) || (blocked && !blk_d)) begin
            count_r <= count_r + 32'h0000_0001;
        end else if (cnt_clr) begin
            count_r <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                hist_r[i] <= 16'h0000;
            end
        end else if (tick) begin
            hist_r[0] <= (pa_s2 > pb_s2) ? ((pa_s2 > pc_s2) ? pa_s2 : pc_s2)
                                         : ((pb_s2 > pc_s2) ? pb_s2 : pc_s2);
            for (int i = 1; i < 8; i++) begin
                hist_r[i] <= hist_r[i-1];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prefault_r <= 16'h0000;
            blk_cur_r  <= 16'h0000;
        end else begin
            if (cold_load_active && !act_d) begin
                prefault_r <= avg[15:0];
            end
            if (blocked && !blk_d) begin
                blk_cur_r <= hist_r[0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Status and APB read
    // ------------------------------------------------------------------------
    clp_pkg::clp_cond_e cond;

    always_comb begin
        if (blocked) begin
            cond = clp_pkg::CLP_COND_BLOCKED;
        end else if (cold_load_active) begin
            cond = clp_pkg::CLP_COND_ACTIVE;
        end else if (over_c) begin
            cond = clp_pkg::CLP_COND_OVER;
        end else if (low_c) begin
            cond = clp_pkg::CLP_COND_LOW;
        end else begin
            cond = clp_pkg::CLP_COND_NORMAL;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr[11:8] == 4'h1) begin
            if (wword < `CLP_GW_START_DELAY_TIME) begin
                prdata = {16'h0000, thr_r[wgrp][2'(wword)]};
            end else if (wword <= `CLP_GW_MINIMUM_HOLD_TIME) begin
                prdata = {12'h000, tim_r[wgrp][2'(wword - `CLP_GW_START_DELAY_TIME)]};
            end
        end else begin
            unique case (paddr)
                `CLP_OFF_CTRL:      prdata = {30'h0000_0000, force_blk_r, force_en_r};
                `CLP_OFF_GROUP_SEL: prdata = {29'h0000_0000, group_sel_r};
                `CLP_OFF_STATUS:    prdata = {24'h00_0000, blk_r, blocked,
                                              cold_load_active, 2'b00, cond};
                `CLP_OFF_COUNT:     prdata = count_r;
                `CLP_OFF_PREFAULT:  prdata = {16'h0000, prefault_r};
                `CLP_OFF_EV_LAST:   prdata = {30'h0000_0000, event_code};
                `CLP_OFF_EV_TIME:   prdata = event_time;
                `CLP_OFF_BLK_CUR:   prdata = {16'h0000, blk_cur_r};
                default:            prdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_over_drops: assert property (@(posedge clk) disable iff (!rst_n)
        eval && over_c |-> !cold_load_active) else $error("active during overcurrent");
    a_no_both_out: assert property (@(posedge clk) disable iff (!rst_n)
        !(cold_load_active && blocked)) else $error("active and blocked together");
    a_act_needs_low: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state_r == clp_pkg::CLP_ST_ACTIVE) |-> $past(low_c) && !$past(blk_r))
        else $error("activation without low unblocked");
    a_blk_needs_blk: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(blocked) |-> $past(blk_r)) else $error("blocked without block");
    a_block_clears: assert property (@(posedge clk) disable iff (!rst_n)
        eval && blk_r && state_r == clp_pkg::CLP_ST_ACTIVE |=> !cold_load_active)
        else $error("block did not clear");
    a_evt_follows: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(cold_load_active) |=> event_valid) else $error("missing event");
    a_cnt_counts: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(cold_load_active) |=> count_r == $past(count_r) + 32'h0000_0001)
        else $error("count not advanced");
    a_cond_code: assert property (@(posedge clk) disable iff (!rst_n)
        blocked |-> cond == clp_pkg::CLP_COND_BLOCKED) else $error("bad condition");
    a_tick_period: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> !tick) else $error("tick too close");
    a_force_blk: assert property (@(posedge clk) disable iff (!rst_n)
        tick && force_en_r |=> blk_r == $past(force_blk_r)) else $error("force ignored");

    c_activate: cover property (@(posedge clk) disable iff (!rst_n) $rose(cold_load_active));
    c_blocked:  cover property (@(posedge clk) disable iff (!rst_n) $rose(blocked));
    c_over_rel: cover property (@(posedge clk) disable iff (!rst_n)
        eval && over_c && state_r == clp_pkg::CLP_ST_ACTIVE);
endmodule : clp_detector

/* File: dv/clp_front_end.sv */
module clp_front_end #(
    parameter int TICK_CYC = 20
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] set_a,
    input  wire logic [15:0] set_b,
    input  wire logic [15:0] set_c,
    input  wire logic        set_blk,
    output logic [15:0]      phase_a_rms,
    output logic [15:0]      phase_b_rms,
    output logic [15:0]      phase_c_rms,
    output logic             block_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // ------------------------------------------------------------------------
    // Measurement refresh
    // ------------------------------------------------------------------------
    // Values move only on the measuring time base, as a real RMS filter does.
    // Blocking moves with them, so it always leads the operate delay by ticks.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
        end else begin
            cnt <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_a_rms <= 16'h0064;
            phase_b_rms <= 16'h0064;
            phase_c_rms <= 16'h0064;
            block_in    <= 1'b0;
        end else if (cnt == 0) begin
            phase_a_rms <= set_a;
            phase_b_rms <= set_b;
            phase_c_rms <= set_c;
            block_in    <= set_blk;
        end
    end
endmodule : clp_front_end

/* File: dv/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, act, blk, ev_v, s_blk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, ev_t, q;
    logic [15:0] sa, sb, sc, pa, pb, pc;
    logic [1:0] ev_c;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    logic blk_in;
    clp_front_end #(.TICK_CYC(20)) clp_front_end_i (.clk(clk), .rst_n(rst_n), .set_a(sa),
        .set_b(sb), .set_c(sc), .set_blk(s_blk), .phase_a_rms(pa), .phase_b_rms(pb),
        .phase_c_rms(pc), .block_in(blk_in));
    clp_detector #(.TICK_CYC(20), .MS_CYC(4)) clp_detector_i (.clk(clk), .rst_n(rst_n),
        .phase_a_rms(pa), .phase_b_rms(pb), .phase_c_rms(pc), .block_in(blk_in),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cold_load_active(act),
        .blocked(blk), .event_valid(ev_v), .event_code(ev_c), .event_time(ev_t));
    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    // Edges since reset release, the reference for the 1 ms event stamps.
    always @(posedge clk) begin
        if (rst_n) begin
            cyc <= cyc + 1;
        end
    end
    task automatic stop_test;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
        chk({31'h0, pslverr}, 32'h0000_0000);
    endtask : rd
    // Waits for an output level, then for the event it must produce.
    task automatic wait_out(input logic which, input logic v, input logic [1:0] code);
        int i;
        i = 0;
        while (((which ? blk : act) !== v) && i < 3000) begin
            @(posedge clk);
            i++;
        end
        chk({31'h0, (which ? blk : act)}, {31'h0, v});
        i = 0;
        while (ev_v !== 1'b1 && i < 8) begin
            @(posedge clk);
            i++;
        end
        chk({30'h0, ev_c}, {30'h0, code});
        chk(ev_t, 32'((cyc - 1) / 4));
    endtask : wait_out
    task automatic phases(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        @(posedge clk);
        sa <= a; sb <= b; sc <= c;
    endtask : phases
    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset;
        chk({30'h0, act, blk}, 32'h0000_0000);
        rd(12'h100, 32'h0000_0014);
        rd(12'h104, 32'h0000_0078);
        rd(12'h108, 32'h0000_00C8);
        rd(12'h10C, 32'h0000_07D0);
        rd(12'h110, 32'h0000_1770);
        rd(12'h114, 32'h0000_0008);
        rd(12'h008, 32'h0000_0000);
    endtask : t_reset
    task automatic t_activate;
        apb(1'b1, 12'h12C, 32'h0000_0002);
        apb(1'b1, 12'h134, 32'h0000_0002);
        apb(1'b1, 12'h004, 32'h0000_0001);
        phases(16'h000A, 16'h000A, 16'h0013);
        wait_out(1'b0, 1'b1, 2'b01);
        rd(12'h008, 32'h0000_0023);
        phases(16'h0064, 16'h0064, 16'h0064);
        wait_out(1'b0, 1'b0, 2'b00);
    endtask : t_activate
    task automatic t_over;
        phases(16'h000A, 16'h000A, 16'h000A);
        wait_out(1'b0, 1'b1, 2'b01);
        phases(16'h000A, 16'h00FA, 16'h000A);
        wait_out(1'b0, 1'b0, 2'b00);
        rd(12'h008, 32'h0000_0002);
        rd(12'h00C, 32'h0000_0002);
        apb(1'b1, 12'h000, 32'h0000_0004);
        rd(12'h00C, 32'h0000_0000);
    endtask : t_over
    task automatic t_block;
        phases(16'h0064, 16'h0064, 16'h0064);
        apb(1'b1, 12'h000, 32'h0000_0003);
        phases(16'h000A, 16'h000A, 16'h000A);
        wait_out(1'b1, 1'b1, 2'b11);
        chk({31'h0, act}, 32'h0000_0000);
        rd(12'h008, 32'h0000_00C4);
        apb(1'b1, 12'h000, 32'h0000_0000);
        wait_out(1'b1, 1'b0, 2'b10);
        rd(12'h0F0, 32'h0000_0000);
    endtask : t_block
    // Blocking through the pin: clears an activation, then blocks the next pick-up.
    task automatic t_pin;
        phases(16'h0032, 16'h0032, 16'h0032);
        repeat (200) @(posedge clk);
        phases(16'h000A, 16'h000A, 16'h000A);
        wait_out(1'b0, 1'b1, 2'b01);
        rd(12'h010, 32'h0000_0032);
        @(posedge clk);
        s_blk <= 1'b1;
        wait_out(1'b0, 1'b0, 2'b00);
        wait_out(1'b1, 1'b1, 2'b11);
        rd(12'h01C, 32'h0000_000A);
        @(posedge clk);
        s_blk <= 1'b0;
        wait_out(1'b1, 1'b0, 2'b10);
        rd(12'h014, 32'h0000_0002);
    endtask : t_pin
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        stop_test;
    end
    initial begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0000_0000; sa = 16'h0064; sb = 16'h0064; sc = 16'h0064; s_blk = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset;
        t_activate;
        t_over;
        t_block;
        t_pin;
        stop_test;
    end
endmodule : tb
